// ---- tb/qpc_counter_tb.sv ----
// self-checking bench for qpc_counter: register tasks, encoder model, read scoreboard
// assumes read data one cycle after the strobe and phases sampled every edge
`timescale 1ns/10ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
	$display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module qpc_counter_tb;
	import qpc_pkg::*;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	qpc_bus_req_t bus_req = '0;
	qpc_phase_t phase_in;
	logic [31:0] rdata_q;
	logic irq_q;
	logic adv = 1'b0, dir = 1'b0, skip = 1'b0, idx = 1'b0;
	logic rd_pend = 1'b0;
	logic [31:0] exp_q[$];
	logic [31:0] e2;
	logic [31:0] v;
	int mismatches = 0;
	int total_checks = 0;

	always #(CLK_PERIOD_NS / 2.0) clk_sys = ~clk_sys;

	qpc_counter i_dut (.clk_sys(clk_sys), .reset(reset), .bus_req(bus_req),
		.phase_in(phase_in), .rdata_q(rdata_q), .irq_q(irq_q));
	qpc_encoder_model i_enc (.clk_sys(clk_sys), .reset(reset), .adv(adv), .dir(dir),
		.skip(skip), .idx(idx), .phase(phase_in));

	// the oldest note is matched against data in the cycle after the strobe
	always @(posedge clk_sys) begin
		if (rd_pend) begin
			e2 = exp_q.pop_front();
			`CHK(rdata_q, e2)
		end
		rd_pend <= bus_req.rd;
	end

	// ----------------------------------------
	// bus and encoder tasks
	// ----------------------------------------
	// a gap cycle after each strobe keeps one assignment per signal per step
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk_sys);
		bus_req.wr <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge clk_sys);
		bus_req.rd <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic step(input logic d, input logic s, input int n);
		repeat (n) begin
			adv <= 1'b1;
			dir <= d;
			skip <= s;
			@(posedge clk_sys);
			adv <= 1'b0;
			repeat (3) @(posedge clk_sys);
		end
	endtask
	task automatic finish_test;
		if (mismatches == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	initial begin
		repeat (5000) @(posedge clk_sys);
		mismatches++;
		finish_test();
	end

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial begin
		void'($urandom(40385));
		repeat (8) @(posedge clk_sys);
		reset <= 1'b0;
		@(posedge clk_sys);
		rd(REG_MASK, 32'h0);
		rd(4'h7, 32'h0);
		wr(REG_COUNT, 32'h5);
		wr(REG_CTRL, 32'h22);
		rd(REG_COUNT, 32'h0);
		rd(REG_CTRL, 32'h21);
		step(1'b1, 1'b0, 4);
		rd(REG_COUNT, 32'h4);
		step(1'b0, 1'b0, 6);
		rd(REG_COUNT, 32'hffff_fffe);
		v = 32'($urandom_range(100, 0));
		wr(REG_COUNT, v);
		rd(REG_COUNT, v);
		step(1'b1, 1'b0, 2);
		rd(REG_COUNT, v + 32'h2);
		rd(REG_STATUS, 32'h0);
		wr(REG_MASK, 32'h0f);
		wr(REG_COUNT, 32'h7f);
		step(1'b1, 1'b0, 1);
		rd(REG_COUNT, 32'hffff_ff80);
		`CHK(irq_q, 1'b1)
		rd(REG_STATUS, 32'h1);
		repeat (3) @(posedge clk_sys);
		`CHK(irq_q, 1'b0)
		step(1'b0, 1'b0, 1);
		rd(REG_STATUS, 32'h2);
		wr(REG_MASK, 32'h0d);
		wr(REG_COUNT, 32'h80);
		step(1'b0, 1'b0, 1);
		repeat (3) @(posedge clk_sys);
		`CHK(irq_q, 1'b0)
		rd(REG_STATUS, 32'h2);
		wr(REG_COUNT, 32'h0);
		step(1'b1, 1'b0, 1);
		wr(REG_STATUS, 32'hff);
		rd(REG_STATUS, 32'h0);
		step(1'b0, 1'b1, 2);
		`CHK(irq_q, 1'b1)
		rd(REG_STATUS, 32'h8);
		wr(REG_COUNT, 32'h9);
		wr(REG_CTRL, 32'h61);
		idx <= 1'b1;
		@(posedge clk_sys);
		idx <= 1'b0;
		repeat (3) @(posedge clk_sys);
		rd(REG_COUNT, 32'h0);
		rd(REG_STATUS, 32'h4);
		// sleep: save state, stop, save config; wake: restore, run again
		rd(REG_CTRL, 32'h61);
		wr(REG_CTRL, 32'h60);
		rd(REG_MASK, 32'h0d);
		step(1'b1, 1'b0, 4);
		step(1'b0, 1'b1, 2);
		rd(REG_COUNT, 32'h0);
		rd(REG_STATUS, 32'h0);
		wr(REG_MASK, 32'h0d);
		wr(REG_CTRL, 32'h61);
		step(1'b1, 1'b0, 4);
		rd(REG_COUNT, 32'h4);
		for (int r = 0; r < 3; r++) begin
			wr(REG_COUNT, 32'h0);
			wr(REG_CTRL, 32'h1 | (32'(r) << 4));
			step(1'b1, 1'b0, 4);
			rd(REG_COUNT, 32'h1 << r);
		end
		for (int s = 0; s < 2; s++) begin
			wr(REG_CTRL, 32'h21 | (32'(s) << 2));
			v = (32'h1 << ((8 << s) - 1)) - 32'h1;
			wr(REG_COUNT, v);
			step(1'b1, 1'b0, 1);
			rd(REG_COUNT, ~v);
			rd(REG_STATUS, 32'h1);
		end
		wr(REG_CTRL, 32'h29);
		wr(REG_MASK, 32'h08);
		rd(REG_MASK, 32'h0f);
		wr(REG_COUNT, 32'h7fff);
		step(1'b1, 1'b0, 1);
		`CHK(irq_q, 1'b1)
		rd(REG_COUNT, 32'hffff_8000);
		rd(REG_STATUS, 32'h1);
		repeat (3) @(posedge clk_sys);
		finish_test();
	end
endmodule

// ---- tb/qpc_encoder_model.sv ----
// encoder model: walks the A/B gray sequence and drives the index line
// assumes the bench pulses adv for one clk_sys cycle per step
`timescale 1ns/10ps
module qpc_encoder_model
	import qpc_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic adv,
	input wire logic dir,
	input wire logic skip,
	input wire logic idx,
	output qpc_pkg::qpc_phase_t phase
);
	logic [1:0] pos_q;
	// skip jumps two states so both phases flip at once, which no real encoder does
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			pos_q <= 2'h0;
		end else if (adv) begin
			pos_q <= skip ? pos_q + 2'h2 : (dir ? pos_q + 2'h1 : pos_q - 2'h1);
		end
	end
	// forward order 00, 01, 11, 10: b leads a
	assign phase = {pos_q[1], pos_q[1] ^ pos_q[0], idx};
endmodule

// ---- verilog/qpc_counter.sv ----
// quadrature position counter: phase sampling, signed count, events, interrupt, register port
// assumes inputs synchronous to clk_sys; register port with one-cycle read latency
//
// Design decisions made here: the address map and the address-and-strobe port.
`timescale 1ns/10ps
// Notes on behaviour
// - start clears count, loads size, resolution and index enable, starts counting
// - count is signed 8, 16 or 32 bits; the 32-bit size keeps only 16 bits
// - B leading A counts upward
// - host may load any signed count value; in the 32-bit size the code keeps only its low 16 bits, sign-extended
// - events reported as bits of 8-bit status
// - illegal A/B change sets illegal flag
// - index clear sets index flag when enabled
// - 8-bit mask, one enables the interrupt
// - 32-bit size ignores writes to wrap/index enables
// - 32-bit size reads those enables as set
// - stop freezes counter and event generation
// - interrupt is OR of enabled status bits
// - read-only status, bits 0-3 defined
// - full resolution gives four counts per cycle
module qpc_counter
	import qpc_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset,
	input wire qpc_pkg::qpc_bus_req_t bus_req,
	input wire qpc_pkg::qpc_phase_t phase_in,
	output logic [31:0] rdata_q,
	output logic irq_q
);
	import qpc_pkg::*;
	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	logic run_q;
	logic index_en_q;
	qpc_size_t size_q;
	qpc_res_t res_q;
	logic [31:0] count_q;
	logic [31:0] count_d;
	logic [7:0] status_q;
	logic [EV_N-1:0] status_ev_q;
	logic [7:0] mask_q;
	logic [7:0] mask_view;
	logic [1:0] ab_q;
	logic primed_q;
	qpc_step_t step;
	logic wr_ctrl;
	logic wr_count;
	logic rd_status;
	logic start_cmd;
	logic index_hit;
	logic wrap_high;
	logic wrap_low;
	logic [EV_N-1:0] ev_set;
	logic [31:0] max_pos;
	logic [31:0] max_neg;
	logic [31:0] size_mask;
	assign wr_ctrl = bus_req.wr && bus_req.addr == REG_CTRL;
	assign wr_count = bus_req.wr && bus_req.addr == REG_COUNT;
	assign rd_status = bus_req.rd && bus_req.addr == REG_STATUS;
	assign start_cmd = wr_ctrl && bus_req.wdata[CTRL_START_BIT];
	// ---------------------------------------------------------------
	// configuration and control
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			run_q <= 1'b0;
			index_en_q <= 1'b0;
			size_q <= QPC_SIZE_8;
			res_q <= QPC_RES_1X;
		end else if (wr_ctrl) begin
			// start forces running; otherwise the run bit turns counting on or off
			run_q <= bus_req.wdata[CTRL_RUN_BIT] | bus_req.wdata[CTRL_START_BIT];
			index_en_q <= bus_req.wdata[CTRL_INDEX_BIT];
			size_q <= qpc_size_t'(bus_req.wdata[CTRL_SIZE_LO +: 2]);
			res_q <= qpc_res_t'(bus_req.wdata[CTRL_RES_LO +: 2]);
		end
	end
	always_comb begin
		case (size_q)
			QPC_SIZE_8: begin
				max_pos = 32'h0000_007f;
				max_neg = 32'hffff_ff80;
				size_mask = 32'h0000_00ff;
			end
			QPC_SIZE_16: begin
				max_pos = 32'h0000_7fff;
				max_neg = 32'hffff_8000;
				size_mask = 32'h0000_ffff;
			end
			default: begin
				// a 32-bit count keeps 16 hardware bits; software extends on each wrap
				max_pos = 32'h0000_7fff;
				max_neg = 32'hffff_8000;
				size_mask = 32'h0000_ffff;
			end
		endcase
	end
	// ---------------------------------------------------------------
	// phase sampling and stepping
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			ab_q <= 2'h0;
			primed_q <= 1'b0;
		end else begin
			ab_q <= {phase_in.phase_a, phase_in.phase_b};
			// first sample after start only seeds the previous value
			// a stop write drops priming at once so no step slips in after it
			primed_q <= run_q && !start_cmd &&
				!(wr_ctrl && !bus_req.wdata[CTRL_RUN_BIT]);
		end
	end
	qpc_step_decode u_step (
		.clk_sys(clk_sys),
		.reset(reset),
		.ab_prev(ab_q),
		.ab_now({phase_in.phase_a, phase_in.phase_b}),
		.res(res_q),
		.step(step)
	);
	assign index_hit = run_q && index_en_q && !phase_in.phase_a && !phase_in.phase_b &&
		phase_in.index;
	assign wrap_high = primed_q && step.up && count_q == max_pos;
	assign wrap_low = primed_q && step.down && count_q == max_neg;
	// ---------------------------------------------------------------
	// position counter
	// ---------------------------------------------------------------
	always_comb begin
		count_d = count_q;
		if (start_cmd) begin
			count_d = COUNT_RESET;
		end else if (wr_count) begin
			count_d = bus_req.wdata;
		end else if (index_hit) begin
			count_d = COUNT_RESET;
		end else if (wrap_high) begin
			count_d = max_neg;
		end else if (wrap_low) begin
			count_d = max_pos;
		end else if (primed_q && step.up) begin
			count_d = count_q + 32'h1;
		end else if (primed_q && step.down) begin
			count_d = count_q - 32'h1;
		end
	end
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			count_q <= COUNT_RESET;
		end else begin
			// sign-extend from the active width so the value reads two's-complement
			case (size_q)
				QPC_SIZE_8: count_q <= {{24{count_d[7]}}, count_d[7:0]};
				default: count_q <= {{16{count_d[15]}}, count_d[15:0]};
			endcase
		end
	end
	// ---------------------------------------------------------------
	// events, mask and interrupt
	// ---------------------------------------------------------------
	assign ev_set[EV_WRAP_HIGH] = wrap_high && !wr_count && !start_cmd && !index_hit;
	assign ev_set[EV_WRAP_LOW] = wrap_low && !wr_count && !start_cmd && !index_hit;
	assign ev_set[EV_INDEX] = index_hit && !wr_count && !start_cmd;
	assign ev_set[EV_ILLEGAL] = primed_q && step.illegal;
	generate
		for (genvar i = 0; i < EV_N; i++) begin : g_ev
			always_ff @(posedge clk_sys or posedge reset) begin
				if (reset) begin
					status_ev_q[i] <= 1'b0;
				end else if (ev_set[i]) begin
					status_ev_q[i] <= 1'b1;
				end else if (rd_status) begin
					status_ev_q[i] <= 1'b0;
				end
			end
		end
	endgenerate
	assign status_q = {4'h0, status_ev_q};
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			mask_q <= MASK_RESET;
		end else if (bus_req.wr && bus_req.addr == REG_MASK) begin
			mask_q <= bus_req.wdata[7:0];
		end
	end
	// 32-bit size pins the wrap and index enables on, whatever was written
	assign mask_view = (size_q == QPC_SIZE_32) ? (mask_q | EV_FIXED_32) : mask_q;
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(status_q & mask_view);
		end
	end
	// ---------------------------------------------------------------
	// register read port
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			rdata_q <= 32'h0000_0000;
		end else if (bus_req.rd) begin
			case (bus_req.addr)
				REG_CTRL: rdata_q <= {25'h0, index_en_q, res_q, size_q, 1'b0, run_q};
				REG_COUNT: rdata_q <= count_q;
				REG_STATUS: rdata_q <= {24'h0, status_q};
				REG_MASK: rdata_q <= {24'h0, mask_view};
				default: rdata_q <= 32'h0000_0000;
			endcase
		end else begin
			rdata_q <= 32'h0000_0000;
		end
	end
	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	a_load_takes: assert property (@(posedge clk_sys) disable iff (reset)
		wr_count && !start_cmd && size_q == QPC_SIZE_16 |=>
		count_q[15:0] == $past(bus_req.wdata[15:0]))
		else $error("count load not applied");
	a_load_no_flag: assert property (@(posedge clk_sys) disable iff (reset)
		wr_count && !rd_status && !ev_set[EV_ILLEGAL] |=> status_q[2:0] == $past(status_q[2:0]))
		else $error("load raised an event");
	a_start_clear: assert property (@(posedge clk_sys) disable iff (reset)
		start_cmd |=> count_q == 32'h0 && run_q)
		else $error("start did not clear count");
	a_stop_freeze: assert property (@(posedge clk_sys) disable iff (reset)
		!run_q && !primed_q && !wr_count && !start_cmd |=> count_q == $past(count_q))
		else $error("stopped counter moved");
	a_irq_or: assert property (@(posedge clk_sys) disable iff (reset)
		##1 irq_q == |($past(status_q) & $past(mask_view)))
		else $error("interrupt not OR of enabled flags");
	a_mask_fixed: assert property (@(posedge clk_sys) disable iff (reset)
		bus_req.rd && bus_req.addr == REG_MASK && size_q == QPC_SIZE_32 |=> rdata_q[2:0] == 3'h7)
		else $error("fixed enables not read as set");
	a_wrap_high: assert property (@(posedge clk_sys) disable iff (reset)
		wrap_high && !wr_count && !start_cmd && !index_hit |=>
		status_q[EV_WRAP_HIGH] && count_q == $past(max_neg))
		else $error("overflow not flagged");
	a_illegal_flag: assert property (@(posedge clk_sys) disable iff (reset)
		primed_q && step.illegal |=> status_q[EV_ILLEGAL])
		else $error("illegal step not flagged");
	a_reserved_zero: assert property (@(posedge clk_sys) disable iff (reset)
		bus_req.rd && bus_req.addr == REG_STATUS |=> rdata_q[31:4] == 28'h0)
		else $error("reserved status bits set");

	// ---------------------------------------------------------------
	// step sequences and further checks
	// ---------------------------------------------------------------
	sequence s_plain_up;
		primed_q && step.up && !wrap_high && !start_cmd && !wr_count && !index_hit && !wr_ctrl;
	endsequence
	sequence s_plain_down;
		primed_q && step.down && !wrap_low && !start_cmd && !wr_count && !index_hit && !wr_ctrl;
	endsequence
	sequence s_start_seen;
		start_cmd ##1 !start_cmd && !wr_ctrl;
	endsequence
	sequence s_index_only;
		index_hit && !wr_count && !start_cmd && !wr_ctrl;
	endsequence
	sequence s_step_1x;
		primed_q && res_q == QPC_RES_1X && (step.up || step.down);
	endsequence

	a_up_step: assert property (@(posedge clk_sys) disable iff (reset)
		s_plain_up |=> count_q == $past(count_q) + 32'h1)
		else $error("up step not counted");
	a_down_step: assert property (@(posedge clk_sys) disable iff (reset)
		s_plain_down |=> count_q == $past(count_q) - 32'h1)
		else $error("down step not counted");
	a_wrap_low: assert property (@(posedge clk_sys) disable iff (reset)
		wrap_low && !wr_count && !start_cmd && !index_hit && !wr_ctrl |=>
		status_q[EV_WRAP_LOW] && count_q == $past(max_pos))
		else $error("underflow not flagged");
	a_load_8: assert property (@(posedge clk_sys) disable iff (reset)
		wr_count && !start_cmd && size_q == QPC_SIZE_8 |=>
		count_q[7:0] == $past(bus_req.wdata[7:0]))
		else $error("8-bit load not applied");
	a_index_clear: assert property (@(posedge clk_sys) disable iff (reset)
		s_index_only |=> count_q == 32'h0 && status_q[EV_INDEX])
		else $error("index did not clear count");
	a_index_off: assert property (@(posedge clk_sys) disable iff (reset)
		!index_en_q && !status_q[EV_INDEX] |=> !status_q[EV_INDEX])
		else $error("index flag while index disabled");

	// priming implies running, so a stopped block makes no event at all
	a_primed_run: assert property (@(posedge clk_sys) disable iff (reset)
		primed_q |-> run_q)
		else $error("stepping while stopped");
	a_stop_quiet: assert property (@(posedge clk_sys) disable iff (reset)
		!run_q && status_q[3:0] == 4'h0 |=> status_q[3:0] == 4'h0)
		else $error("event raised while stopped");
	a_start_prime: assert property (@(posedge clk_sys) disable iff (reset)
		s_start_seen |=> primed_q)
		else $error("counting not begun after start");
	a_start_seed: assert property (@(posedge clk_sys) disable iff (reset)
		start_cmd |=> !primed_q)
		else $error("first sample after start counted");

	a_status_clear: assert property (@(posedge clk_sys) disable iff (reset)
		rd_status && ev_set == 4'h0 |=> status_q == 8'h00)
		else $error("status not cleared by read");
	a_set_wins: assert property (@(posedge clk_sys) disable iff (reset)
		rd_status && ev_set[EV_ILLEGAL] |=> status_q[EV_ILLEGAL])
		else $error("new event lost to read clear");
	a_read_status: assert property (@(posedge clk_sys) disable iff (reset)
		rd_status |=> rdata_q == {24'h0, $past(status_q)})
		else $error("status read data wrong");
	a_status_ro: assert property (@(posedge clk_sys) disable iff (reset)
		bus_req.wr && bus_req.addr == REG_STATUS && ev_set == 4'h0 |=>
		status_q == $past(status_q))
		else $error("status changed by write");
	a_rdata_idle: assert property (@(posedge clk_sys) disable iff (reset)
		!bus_req.rd |=> rdata_q == 32'h0)
		else $error("read data outside read cycle");

	a_read_count: assert property (@(posedge clk_sys) disable iff (reset)
		bus_req.rd && bus_req.addr == REG_COUNT |=> rdata_q == $past(count_q))
		else $error("count read data wrong");
	a_ext_8: assert property (@(posedge clk_sys) disable iff (reset)
		size_q == QPC_SIZE_8 |=> count_q[31:8] == {24{count_q[7]}})
		else $error("8-bit count not sign-extended");
	a_ext_16: assert property (@(posedge clk_sys) disable iff (reset)
		size_q != QPC_SIZE_8 |=> count_q[31:16] == {16{count_q[15]}})
		else $error("16-bit count not sign-extended");

	a_mask_store: assert property (@(posedge clk_sys) disable iff (reset)
		bus_req.wr && bus_req.addr == REG_MASK |=> mask_q == $past(bus_req.wdata[7:0]))
		else $error("mask write lost");
	a_mask_block: assert property (@(posedge clk_sys) disable iff (reset)
		mask_view == 8'h00 |=> !irq_q)
		else $error("interrupt with all events masked");
	a_fixed_on: assert property (@(posedge clk_sys) disable iff (reset)
		size_q == QPC_SIZE_32 |-> mask_view[2:0] == 3'h7)
		else $error("fixed enables not active");

	a_one_x: assert property (@(posedge clk_sys) disable iff (reset)
		s_step_1x |-> ab_q == 2'h0 || {phase_in.phase_a, phase_in.phase_b} == 2'h0)
		else $error("1x counted off the rest state");
	a_four_x: assert property (@(posedge clk_sys) disable iff (reset)
		primed_q && res_q == QPC_RES_4X && !step.illegal &&
		ab_q != {phase_in.phase_a, phase_in.phase_b} |-> step.up || step.down)
		else $error("4x missed a legal step");
endmodule

// ---- verilog/qpc_pkg.sv ----
// package for the quadrature position counter: register map, fields, reset values
// assumes a single 40 MHz system clock and a plain strobe register port
package qpc_pkg;
	localparam int CLK_PERIOD_NS = 25;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;
	// ---------------------------------------------------------------
	// register offsets
	// ---------------------------------------------------------------
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_COUNT = 4'h1;
	localparam logic [3:0] REG_STATUS = 4'h2;
	localparam logic [3:0] REG_MASK = 4'h3;
	// ---------------------------------------------------------------
	// control fields
	// ---------------------------------------------------------------
	localparam int CTRL_RUN_BIT = 0;
	localparam int CTRL_START_BIT = 1;
	localparam int CTRL_SIZE_LO = 2;
	localparam int CTRL_RES_LO = 4;
	localparam int CTRL_INDEX_BIT = 6;
	// ---------------------------------------------------------------
	// status and mask bit positions
	// ---------------------------------------------------------------
	localparam int EV_WRAP_HIGH = 0;
	localparam int EV_WRAP_LOW = 1;
	localparam int EV_INDEX = 2;
	localparam int EV_ILLEGAL = 3;
	localparam int EV_N = 4;
	localparam logic [7:0] EV_FIXED_32 = 8'h07;
	localparam logic [7:0] MASK_RESET = 8'h00;
	localparam logic [31:0] COUNT_RESET = 32'h0000_0000;
	typedef enum logic [1:0] {
		QPC_SIZE_8 = 2'h0,
		QPC_SIZE_16 = 2'h1,
		QPC_SIZE_32 = 2'h2
	} qpc_size_t;
	typedef enum logic [1:0] {
		QPC_RES_1X = 2'h0,
		QPC_RES_2X = 2'h1,
		QPC_RES_4X = 2'h2
	} qpc_res_t;
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} qpc_bus_req_t;
	typedef struct packed {
		logic phase_a;
		logic phase_b;
		logic index;
	} qpc_phase_t;
	typedef struct packed {
		logic up;
		logic down;
		logic illegal;
	} qpc_step_t;
endpackage

// ---- verilog/qpc_step_decode.sv ----
// quadrature step decoder: compares previous and current A/B samples
// assumes phase inputs already synchronous to clk_sys
`timescale 1ns/10ps
module qpc_step_decode
	import qpc_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [1:0] ab_prev,
	input wire logic [1:0] ab_now,
	input wire qpc_pkg::qpc_res_t res,
	output qpc_pkg::qpc_step_t step
);
	logic fwd;
	logic rev;
	logic keep;
	// gray sequence 00 -> 01 -> 11 -> 10 -> 00 (B leads A, bit1=A, bit0=B... see below)
	always_comb begin
		// ab = {a,b}; forward (b leads a): 00->01->11->10->00
		fwd = (ab_prev == 2'h0 && ab_now == 2'h1) || (ab_prev == 2'h1 && ab_now == 2'h3) ||
			(ab_prev == 2'h3 && ab_now == 2'h2) || (ab_prev == 2'h2 && ab_now == 2'h0);
		rev = (ab_now == 2'h0 && ab_prev == 2'h1) || (ab_now == 2'h1 && ab_prev == 2'h3) ||
			(ab_now == 2'h3 && ab_prev == 2'h2) || (ab_now == 2'h2 && ab_prev == 2'h0);
		// lower resolutions count only on a subset of the edges
		case (res)
			QPC_RES_4X: keep = 1'b1;
			QPC_RES_2X: keep = (ab_prev == 2'h0) || (ab_prev == 2'h3);
			default: keep = (fwd && ab_prev == 2'h0) || (rev && ab_now == 2'h0);
		endcase
		step.up = fwd && keep;
		step.down = rev && keep;
		step.illegal = (ab_prev ^ ab_now) == 2'h3;
	end
endmodule
